// file: verilog/reset_and_power_mode_control.sv
// Reset and power-mode sequencer with its special function registers
module reset_and_power_mode_control #(
	parameter int unsigned LONG_CYCLES = rpm_pkg::LONG_RESET_CYCLES,
	parameter int unsigned SHORT_CYCLES = rpm_pkg::SHORT_RESET_CYCLES,
	parameter int unsigned POR_CYCLES = rpm_pkg::POR_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic ext_reset_pin,
	input wire logic dvdd_below_por,
	input wire logic supply_below_brownout,
	input wire logic avdd_below_lvd,
	input wire logic dvdd_below_lvd,
	input wire logic watchdog_hw_enable,
	input wire logic brownout_hw_enable,
	input wire logic [1:0] brownout_hw_level,
	input wire logic irq_pending,
	output logic sys_reset,
	output logic pins_high,
	output logic pins_retain,
	output logic osc_stop,
	output logic state_hold,
	output logic cpu_stop,
	output logic timers_stop,
	output logic usarts_stop,
	output logic clocks_halted,
	output logic [7:0] periph_power_down,
	output logic [7:0] clk_divider,
	output logic system_clock_divider_tick,
	output logic [1:0] brownout_level,
	output logic [3:0] lvd_level,
	output logic lvd_analog_irq,
	output logic lvd_digital_irq
);

	// ***************************************************************
	// Input synchronisers
	// ***************************************************************
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] sync_a_q;
	logic [NSYNC-1:0] sync_b_q;
	logic [NSYNC-1:0] async_in;
	assign async_in = {dvdd_below_lvd, avdd_below_lvd, supply_below_brownout,
		dvdd_below_por, ext_reset_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					sync_a_q[gi] <= 1'b0;
					sync_b_q[gi] <= 1'b0;
				end else begin
					sync_a_q[gi] <= async_in[gi];
					sync_b_q[gi] <= sync_a_q[gi];
				end
			end
		end
	endgenerate

	logic pin_s;
	logic por_low_s;
	logic brown_s;
	logic avdd_low_s;
	logic dvdd_low_s;
	assign pin_s = sync_b_q[0];
	assign por_low_s = sync_b_q[1];
	assign brown_s = sync_b_q[2];
	assign avdd_low_s = sync_b_q[3];
	assign dvdd_low_s = sync_b_q[4];

	logic pin_prev_q;
	logic avdd_prev_q;
	logic dvdd_prev_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_prev_q <= 1'b0;
			avdd_prev_q <= 1'b0;
			dvdd_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_s;
			avdd_prev_q <= avdd_low_s;
			dvdd_prev_q <= dvdd_low_s;
		end
	end

	// ***************************************************************
	// Registers and state declarations
	// ***************************************************************
	logic [7:0] power_control_q;
	logic [7:0] sysdiv_q;
	logic [7:0] low_voltage_detect_control_q;
	logic [7:0] peripheral_power_down_q;
	logic [7:0] watchdog_control_q;
	logic [4:0] cause_q;
	rpm_pkg::seq_state_t state_q;
	logic [rpm_pkg::CNT_W-1:0] cnt_q;
	logic [rpm_pkg::CNT_W-1:0] len_q;
	logic [rpm_pkg::CNT_W-1:0] por_cnt_q;
	logic [rpm_pkg::CNT_W-1:0] wdt_cnt_q;
	logic [7:0] div_cnt_q;

	logic in_reset;
	logic stopped;
	logic wr_ok;
	assign in_reset = (state_q != rpm_pkg::ST_RUN);
	assign stopped = power_control_q[rpm_pkg::POWER_CONTROL_STOP_BIT];
	assign wr_ok = sfr_wr && !in_reset;

	// Brownout hold keeps register contents; clearing waits for the count
	logic held;
	logic reg_clear;

	assign held = (state_q == rpm_pkg::ST_BROWN_HOLD);
	assign reg_clear = in_reset && !held; // R10

	// ***************************************************************
	// Reset causes
	// ***************************************************************
	logic pin_fall;
	logic por_trip;
	logic bor_en;
	logic bor_low;
	logic sw_req;
	logic wdt_expire;
	logic long_start;
	logic [rpm_pkg::WDT_EXP_W-1:0] wdt_exp;
	logic wdt_exp_ok;

	assign pin_fall = pin_prev_q && !pin_s; // R3
	assign bor_en = brownout_hw_enable; // R9
	assign bor_low = bor_en && brown_s && !stopped; // R19
	assign por_trip = !bor_en && por_low_s &&
		(por_cnt_q >= rpm_pkg::CNT_W'(POR_CYCLES)); // R11 R12
	assign sw_req = wr_ok && (sfr_addr == rpm_pkg::ADDR_SYSTEM_RESET_TRIGGER) &&
		sfr_wdata[rpm_pkg::SRT_TRIGGER_BIT]; // R7
	// Exponents past the counter width never expire
	assign wdt_exp = watchdog_control_q[rpm_pkg::WDT_EXP_LSB +: rpm_pkg::WDT_EXP_W];
	assign wdt_exp_ok = (wdt_exp < rpm_pkg::WDT_EXP_W'(rpm_pkg::CNT_W));
	assign wdt_expire = watchdog_hw_enable && watchdog_control_q[rpm_pkg::WDT_RUN_BIT] &&
		!stopped && !in_reset && wdt_exp_ok && wdt_cnt_q[wdt_exp]; // R8
	assign long_start = pin_fall || sw_req || wdt_expire;

	// Time spent below the power-on threshold
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !por_low_s) begin
			por_cnt_q <= '0;
		end else if (por_cnt_q < rpm_pkg::CNT_W'(POR_CYCLES)) begin
			por_cnt_q <= por_cnt_q + 1'b1; // R11
		end
	end

	// ***************************************************************
	// Reset sequencer
	// ***************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= rpm_pkg::ST_RUN;
			cnt_q <= '0;
			len_q <= '0;
		end else if (pin_s) begin
			state_q <= rpm_pkg::ST_PIN_HELD; // R3
			cnt_q <= '0;
		end else if (por_trip) begin
			state_q <= rpm_pkg::ST_POR_HOLD; // R12
			cnt_q <= '0;
		end else if (bor_low) begin
			state_q <= rpm_pkg::ST_BROWN_HOLD; // R10
			cnt_q <= '0;
		end else begin
			case (state_q)
				rpm_pkg::ST_RUN, rpm_pkg::ST_COUNT: begin
					if (long_start) begin
						state_q <= rpm_pkg::ST_COUNT; // R4 R23
						cnt_q <= '0;
						len_q <= rpm_pkg::CNT_W'(LONG_CYCLES);
					end else if (state_q == rpm_pkg::ST_COUNT) begin
						if (cnt_q >= len_q - 1'b1) begin
							state_q <= rpm_pkg::ST_RUN; // R23
						end else begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
				end
				rpm_pkg::ST_PIN_HELD, rpm_pkg::ST_POR_HOLD: begin
					state_q <= rpm_pkg::ST_COUNT; // R3
					cnt_q <= '0;
					len_q <= rpm_pkg::CNT_W'(LONG_CYCLES);
				end
				rpm_pkg::ST_BROWN_HOLD: begin
					state_q <= rpm_pkg::ST_COUNT; // R5 R10
					cnt_q <= '0;
					len_q <= rpm_pkg::CNT_W'(SHORT_CYCLES);
				end
				default: begin
					state_q <= rpm_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Last reset cause, shown on reads of the trigger register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cause_q <= 5'h01;
		end else if (por_trip) begin
			cause_q <= 5'h01; // R1
		end else if (pin_fall) begin
			cause_q <= 5'h02; // R1
		end else if (sw_req) begin
			cause_q <= 5'h04; // R1
		end else if (wdt_expire) begin
			cause_q <= 5'h08; // R1
		end else if (bor_low) begin
			cause_q <= 5'h10; // R1
		end
	end

	// ***************************************************************
	// Watchdog counter
	// ***************************************************************
	logic wdt_refresh;
	assign wdt_refresh = wr_ok && (sfr_addr == rpm_pkg::ADDR_WATCHDOG_CONTROL) &&
		sfr_wdata[rpm_pkg::WDT_REFRESH_BIT];

	always_ff @(posedge ref_clk) begin
		if (!rst_n || in_reset || wdt_refresh || !watchdog_control_q[rpm_pkg::WDT_RUN_BIT]) begin
			wdt_cnt_q <= '0;
		end else if (!stopped) begin
			wdt_cnt_q <= wdt_cnt_q + 1'b1; // R8
		end
	end

	// ***************************************************************
	// Register writes
	// ***************************************************************
	logic idle_wake;
	assign idle_wake = power_control_q[rpm_pkg::POWER_CONTROL_IDLE_BIT] && irq_pending; // R15

	always_ff @(posedge ref_clk) begin
		if (!rst_n || reg_clear) begin
			power_control_q <= rpm_pkg::POWER_CONTROL_RST; // R19
		end else if (wr_ok && sfr_addr == rpm_pkg::ADDR_POWER_CONTROL) begin
			power_control_q <= sfr_wdata; // R14 R18
		end else if (idle_wake) begin
			power_control_q[rpm_pkg::POWER_CONTROL_IDLE_BIT] <= 1'b0; // R15
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || reg_clear) begin
			sysdiv_q <= rpm_pkg::SYSTEM_CLOCK_DIVIDER_RST;
			low_voltage_detect_control_q <= rpm_pkg::LOW_VOLTAGE_DETECT_CONTROL_RST;
			peripheral_power_down_q <= rpm_pkg::PERIPHERAL_POWER_DOWN_RST;
			watchdog_control_q <= rpm_pkg::WATCHDOG_CONTROL_RST;
		end else if (wr_ok) begin
			case (sfr_addr)
				rpm_pkg::ADDR_SYSTEM_CLOCK_DIVIDER: sysdiv_q <= sfr_wdata; // R16
				rpm_pkg::ADDR_LOW_VOLTAGE_DETECT_CONTROL: low_voltage_detect_control_q <= sfr_wdata; // R13
				rpm_pkg::ADDR_PERIPHERAL_POWER_DOWN: peripheral_power_down_q <= sfr_wdata; // R16 R21
				rpm_pkg::ADDR_WATCHDOG_CONTROL: begin
					watchdog_control_q <= sfr_wdata & ~(8'h01 << rpm_pkg::WDT_REFRESH_BIT); // R8
				end
				default: begin
				end
			endcase
		end
	end

	// ***************************************************************
	// Register reads
	// ***************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				rpm_pkg::ADDR_POWER_CONTROL: sfr_rdata <= power_control_q;
				rpm_pkg::ADDR_SYSTEM_CLOCK_DIVIDER: sfr_rdata <= sysdiv_q;
				rpm_pkg::ADDR_LOW_VOLTAGE_DETECT_CONTROL: sfr_rdata <= low_voltage_detect_control_q;
				rpm_pkg::ADDR_PERIPHERAL_POWER_DOWN: sfr_rdata <= peripheral_power_down_q;
				rpm_pkg::ADDR_SYSTEM_RESET_TRIGGER: sfr_rdata <= {3'h0, cause_q};
				rpm_pkg::ADDR_WATCHDOG_CONTROL: sfr_rdata <= watchdog_control_q;
				default: sfr_rdata <= 8'h00; // R22
			endcase
		end
	end

	// ***************************************************************
	// System clock divider
	// ***************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n || stopped) begin
			div_cnt_q <= 8'h00;
			system_clock_divider_tick <= 1'b0; // R18
		end else if (div_cnt_q >= sysdiv_q) begin
			div_cnt_q <= 8'h00;
			system_clock_divider_tick <= 1'b1; // R16
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
			system_clock_divider_tick <= 1'b0;
		end
	end

	// ***************************************************************
	// Low-voltage detect interrupts
	// ***************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lvd_analog_irq <= 1'b0;
			lvd_digital_irq <= 1'b0;
		end else begin
			lvd_analog_irq <= low_voltage_detect_control_q[rpm_pkg::LVD_ANA_EN_BIT] &&
				avdd_low_s && !avdd_prev_q; // R13
			lvd_digital_irq <= low_voltage_detect_control_q[rpm_pkg::LVD_DIG_EN_BIT] &&
				dvdd_low_s && !dvdd_prev_q; // R13
		end
	end

	// ***************************************************************
	// Reset drive
	// ***************************************************************
	logic hold_exit;
	logic reset_on;

	// Brownout reset starts only when the supply comes back from a brownout hold
	assign hold_exit = held && !bor_low; // R5 R10
	assign reset_on = (in_reset && !held) ||
		hold_exit || pin_s ||
		por_trip || long_start; // R6 R23

	// ***************************************************************
	// Control outputs
	// ***************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sys_reset <= 1'b1;
			pins_high <= 1'b1;
			pins_retain <= 1'b0;
			osc_stop <= 1'b0;
			state_hold <= 1'b0;
			cpu_stop <= 1'b0;
			timers_stop <= 1'b0;
			usarts_stop <= 1'b0;
			clocks_halted <= 1'b0;
			periph_power_down <= 8'h00;
			clk_divider <= 8'h00;
			brownout_level <= 2'h0;
			lvd_level <= 4'h0;
		end else begin
			sys_reset <= reset_on; // R23
			pins_high <= reset_on; // R6
			pins_retain <= stopped && !pin_s; // R20
			osc_stop <= pin_s; // R3
			state_hold <= bor_low; // R10
			cpu_stop <= power_control_q[rpm_pkg::POWER_CONTROL_IDLE_BIT] || stopped; // R14
			timers_stop <= power_control_q[rpm_pkg::POWER_CONTROL_IDLE_BIT] || stopped; // R14
			usarts_stop <= power_control_q[rpm_pkg::POWER_CONTROL_IDLE_BIT] || stopped; // R14
			clocks_halted <= stopped; // R18
			periph_power_down <= peripheral_power_down_q; // R21
			clk_divider <= sysdiv_q; // R17
			brownout_level <= brownout_hw_level; // R9
			lvd_level <= low_voltage_detect_control_q[rpm_pkg::LVD_LEVEL_W-1:0]; // R13
		end
	end

endmodule : reset_and_power_mode_control

// file: verilog/rpm_pkg.sv
// Constants for the reset and power-mode sequencer
// Operation
// R1: Five reset causes: power-on, external pin, software write, watchdog, brownout.
// R2: Outside party holds reset pin high two oscillator periods, then low.
// R3: Pin high stops oscillators, drives pins high; its falling edge starts reset.
// R4: External, software and watchdog resets finish after 2^17 clocks.
// R5: Brownout reset finishes after 2^15 clocks.
// R6: Every reset cause forces digital pins high from its start.
// R7: Writing the system reset trigger register at 0F7h resets the device.
// R8: Watchdog reset enabled by config bit, controlled by register at 0FFh.
// R9: Brownout reset works only when enabled by config register one.
// R10: Below brownout threshold hold state; reset once supply rises back.
// R11: Power-on reset only after supply below 1.0V longer than 200ms.
// R12: With brownout reset enabled, power-on reset has no effect.
// R13: Separate analog and digital low-voltage interrupts, level set at E7h.
// R14: Idle bit at 087h stops CPU, basic timers and USARTs only.
// R15: Any enabled interrupt ends idle mode.
// R16: Power-down register 0F1h switches peripherals off; 0C7h divides system clock.
// R17: System clock divider also scales the converter clock.
// R18: Stop bit halts every internal clock.
// R19: Stop ends only by external or power-on reset, not brownout.
// R20: In stop mode digital pins keep their values.
// R21: Writing 0FFh to power-down register powers down every peripheral.
// R22: Unassigned register reads return zero; writes there are ignored.
// R23: New reset cause restarts the completion count; reset held until done.
package rpm_pkg;

	// ***************************************************************
	// Register addresses
	// ***************************************************************
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_SYSTEM_CLOCK_DIVIDER = 8'hC7;
	localparam logic [7:0] ADDR_LOW_VOLTAGE_DETECT_CONTROL = 8'hE7;
	localparam logic [7:0] ADDR_PERIPHERAL_POWER_DOWN = 8'hF1;
	localparam logic [7:0] ADDR_SYSTEM_RESET_TRIGGER = 8'hF7;
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hFF;

	// ***************************************************************
	// Field positions
	// ***************************************************************
	localparam int POWER_CONTROL_IDLE_BIT = 0;
	localparam int POWER_CONTROL_STOP_BIT = 1;
	localparam int SRT_TRIGGER_BIT = 0;
	localparam int LVD_DIG_EN_BIT = 4;
	localparam int LVD_ANA_EN_BIT = 5;
	localparam int WDT_RUN_BIT = 7;
	localparam int WDT_REFRESH_BIT = 6;
	localparam int WDT_EXP_LSB = 0;
	localparam int WDT_EXP_W = 5;
	localparam int LVD_LEVEL_W = 4;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
	localparam logic [7:0] SYSTEM_CLOCK_DIVIDER_RST = 8'h00;
	localparam logic [7:0] LOW_VOLTAGE_DETECT_CONTROL_RST = 8'h00;
	localparam logic [7:0] PERIPHERAL_POWER_DOWN_RST = 8'h00;
	localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h1F;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int LONG_RESET_EXP = 17;
	localparam int SHORT_RESET_EXP = 15;
	localparam int unsigned LONG_RESET_CYCLES = 32'd1 << LONG_RESET_EXP;
	localparam int unsigned SHORT_RESET_CYCLES = 32'd1 << SHORT_RESET_EXP;
	localparam int unsigned POR_TIME_MS = 200;
	localparam int unsigned POR_CYCLES =
		32'((64'(POR_TIME_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000);
	localparam int CNT_W = 24;

	// ***************************************************************
	// Sequencer states
	// ***************************************************************
	typedef enum logic [2:0] {
		ST_RUN,
		ST_PIN_HELD,
		ST_POR_HOLD,
		ST_BROWN_HOLD,
		ST_COUNT
	} seq_state_t;

endpackage : rpm_pkg

// file: testbench/rpm_checker_assertions.sv
// Checker for the reset and power-mode sequencer ports
module rpm_checker #(
	parameter int unsigned SHORT_CYCLES = rpm_pkg::SHORT_RESET_CYCLES
) (
	input logic ref_clk,
	input logic rst_n,
	input logic [7:0] sfr_addr,
	input logic sfr_wr,
	input logic sfr_rd,
	input logic [7:0] sfr_wdata,
	input logic [7:0] sfr_rdata,
	input logic ext_reset_pin,
	input logic supply_below_brownout,
	input logic brownout_hw_enable,
	input logic irq_pending,
	input logic sys_reset,
	input logic pins_high,
	input logic osc_stop,
	input logic state_hold,
	input logic cpu_stop,
	input logic timers_stop,
	input logic usarts_stop,
	input logic pins_retain,
	input logic clocks_halted,
	input logic system_clock_divider_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	// ***************************************************************
	// Reset length counter
	// ***************************************************************
	logic arm_q;
	logic [31:0] cnt_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			arm_q <= 1'b0;
			cnt_q <= 32'h0;
		end else if (!sys_reset) begin
			arm_q <= 1'b1;
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end
	// ***************************************************************
	// Properties
	// ***************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	property p_sw;
		sfr_wr && sfr_addr == 8'hF7 && sfr_wdata[0] && !sys_reset && !state_hold
			|=> sys_reset && pins_high;
	endproperty
	a_sw: assert property (p_sw) else $error("software reset missing");
	property p_len;
		$fell(sys_reset) && arm_q |-> cnt_q >= SHORT_CYCLES;
	endproperty
	a_len: assert property (p_len) else $error("reset too short");
	property p_pin;
		ext_reset_pin [*4] |-> sys_reset && osc_stop && pins_high;
	endproperty
	a_pin: assert property (p_pin) else $error("pin hold not seen");
	property p_bor;
		(brownout_hw_enable && supply_below_brownout && !clocks_halted && !sys_reset) [*4]
			|-> state_hold;
	endproperty
	a_bor: assert property (p_bor) else $error("brownout hold missing");
	property p_idle;
		sfr_wr && sfr_addr == 8'h87 && sfr_wdata == 8'h01 && !sys_reset && !irq_pending &&
			!state_hold
			|-> ##2 cpu_stop && timers_stop && usarts_stop && !pins_retain;
	endproperty
	a_idle: assert property (p_idle) else $error("idle not entered");
	property p_wake;
		cpu_stop && !clocks_halted && irq_pending |-> ##[1:3] !cpu_stop;
	endproperty
	a_wake: assert property (p_wake) else $error("idle not left");
	property p_stop;
		sfr_wr && sfr_addr == 8'h87 && sfr_wdata == 8'h02 && !sys_reset && !state_hold
			|-> ##2 clocks_halted && pins_retain && cpu_stop;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not entered");
	property p_tick;
		clocks_halted |-> !system_clock_divider_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick in stop");
	property p_stay;
		(clocks_halted && !ext_reset_pin) [*8] |=> clocks_halted;
	endproperty
	a_stay: assert property (p_stay) else $error("stop left early");
	property p_unmap;
		sfr_rd && !(sfr_addr inside {8'h87, 8'hC7, 8'hE7, 8'hF1, 8'hF7, 8'hFF})
			|=> sfr_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
endmodule : rpm_checker

bind reset_and_power_mode_control rpm_checker #(.SHORT_CYCLES(SHORT_CYCLES)) rpm_checker_i (.*);

// file: testbench/supply_model.sv
// Model of the external reset circuit and supply monitors
module supply_model (
	input logic ref_clk,
	output logic ext_reset_pin,
	output logic dvdd_below_por,
	output logic supply_below_brownout,
	output logic avdd_below_lvd,
	output logic dvdd_below_lvd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] lvl_q = 5'h00;
	assign {dvdd_below_lvd, avdd_below_lvd, supply_below_brownout} = lvl_q[4:2];
	assign {dvdd_below_por, ext_reset_pin} = lvl_q[1:0];
	// Raise one line for n clocks; callers keep n at two or more
	task automatic dip(input int sel, input int n);
		@(posedge ref_clk);
		lvl_q[sel] <= 1'b1;
		repeat (n) @(posedge ref_clk);
		lvl_q[sel] <= 1'b0;
	endtask : dip
endmodule : supply_model

// file: testbench/tb.sv
// Testbench for the reset and power-mode sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LONG = 64;
	localparam int SHORT = 16;
	localparam int PORC = 20;
	logic ref_clk = 1'b0;
	logic rst_n, sfr_wr, sfr_rd, watchdog_hw_enable, brownout_hw_enable, irq_pending;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, periph_power_down, clk_divider;
	logic [1:0] brownout_hw_level, brownout_level;
	logic [3:0] lvd_level;
	logic ext_reset_pin, dvdd_below_por, supply_below_brownout, avdd_below_lvd, dvdd_below_lvd;
	logic sys_reset, pins_high, pins_retain, osc_stop, state_hold, cpu_stop, timers_stop;
	logic usarts_stop, clocks_halted, system_clock_divider_tick, lvd_analog_irq, lvd_digital_irq;
	int n_fail = 0;
	int checks = 0;
	always #10 ref_clk = ~ref_clk;
	reset_and_power_mode_control #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT), .POR_CYCLES(PORC))
		reset_and_power_mode_control_i (.*);
	supply_model supply_model_i (.*);
	task automatic conclude();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1;
		chk(nm, 32'(e), 32'(sfr_rdata));
	endtask : rd
	task automatic meas(input int lo, input int hi, input string nm);
		int n;
		n = 0;
		for (int i = 0; i < 40 && sys_reset !== 1'b1; i++) cyc(1);
		while (sys_reset === 1'b1 && n < hi + 10) begin
			cyc(1);
			n++;
		end
		if (n == 0 || n >= hi + 10) begin
			n_fail++;
			$display("[ERR] %s expected end seen timeout", nm);
			conclude();
		end else begin
			chk(nm, 1, 32'(n >= lo && n <= hi));
		end
	endtask : meas
	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_regs();
		logic [7:0] a [6] = '{8'h87, 8'hC7, 8'hE7, 8'hF1, 8'hFF, 8'h80};
		logic [7:0] e [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h00};
		int n;
		for (int i = 0; i < 6; i++) rd(a[i], e[i], "reset_value");
		rd(8'hF7, 8'h01, "cause_power_on");
		wr(8'h81, 8'hAA);
		rd(8'h81, 8'h00, "unmapped");
		wr(8'hC7, 8'h03);
		wr(8'hF1, 8'hFF);
		wr(8'hE7, 8'h35);
		rd(8'hC7, 8'h03, "divider");
		cyc(2);
		chk("clk_divider", 8'h03, clk_divider);
		chk("periph_power_down", 8'hFF, periph_power_down);
		chk("lvd_level", 4'h5, lvd_level);
		chk("brownout_level", 2'h2, brownout_level);
		n = 0;
		repeat (16) begin
			cyc(1);
			if (system_clock_divider_tick === 1'b1) n++;
		end
		chk("tick_count", 4, n);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_lvd();
		int n;
		for (int s = 3; s < 5; s++) begin
			n = 0;
			fork
				supply_model_i.dip(s, 6);
				repeat (14) begin
					cyc(1);
					if ((s == 3 ? lvd_analog_irq : lvd_digital_irq) === 1'b1) n++;
				end
			join
			chk("lvd_pulses", 1, n);
		end
		$display("t_lvd done");
	endtask : t_lvd
	task automatic t_resets();
		wr(8'hF7, 8'h01);
		#1;
		chk("pins_high", 1, pins_high);
		meas(LONG, LONG + 4, "sw_len");
		rd(8'hC7, 8'h00, "cleared");
		rd(8'hF7, 8'h04, "cause_sw");
		@(posedge ref_clk);
		watchdog_hw_enable <= 1'b1;
		wr(8'hFF, 8'h83);
		meas(LONG, LONG + 4, "wdt_len");
		rd(8'hF7, 8'h08, "cause_wdt");
		@(posedge ref_clk);
		watchdog_hw_enable <= 1'b0;
		fork
			supply_model_i.dip(0, 6);
			begin
				cyc(5);
				chk("pin_held", 2'b11, {osc_stop, pins_high});
			end
		join
		cyc(20);
		supply_model_i.dip(0, 2);
		meas(LONG, LONG + 6, "pin_restart_len");
		rd(8'hF7, 8'h02, "cause_pin");
		$display("t_resets done");
	endtask : t_resets
	task automatic t_bor();
		@(posedge ref_clk);
		brownout_hw_enable <= 1'b1;
		fork
			supply_model_i.dip(2, 10);
			begin
				cyc(8);
				chk("hold", 2'b10, {state_hold, sys_reset});
			end
		join
		meas(SHORT, SHORT + 4, "bor_len");
		rd(8'hF7, 8'h10, "cause_bor");
		supply_model_i.dip(1, PORC + 10);
		cyc(4);
		chk("por_masked", 0, sys_reset);
		@(posedge ref_clk);
		brownout_hw_enable <= 1'b0;
		supply_model_i.dip(2, 10);
		cyc(4);
		chk("bor_off", 0, sys_reset);
		supply_model_i.dip(1, PORC - 8);
		cyc(4);
		chk("short_dip", 0, sys_reset);
		supply_model_i.dip(1, PORC + 8);
		meas(LONG, LONG + 8, "por_len");
		rd(8'hF7, 8'h01, "cause_por");
		$display("t_bor done");
	endtask : t_bor
	task automatic t_modes();
		wr(8'h87, 8'h01);
		cyc(2);
		chk("idle_stops", 3'b111, {cpu_stop, timers_stop, usarts_stop});
		chk("idle_pins", 2'b00, {clocks_halted, pins_retain});
		@(posedge ref_clk);
		irq_pending <= 1'b1;
		cyc(3);
		chk("idle_wake", 0, cpu_stop);
		@(posedge ref_clk);
		irq_pending <= 1'b0;
		brownout_hw_enable <= 1'b1;
		wr(8'h87, 8'h02);
		cyc(2);
		chk("stop", 2'b11, {clocks_halted, pins_retain});
		supply_model_i.dip(2, 10);
		cyc(4);
		chk("bor_no_wake", 2'b10, {clocks_halted, sys_reset});
		supply_model_i.dip(0, 3);
		meas(LONG, LONG + 6, "stop_wake_len");
		chk("awake", 0, clocks_halted);
		$display("t_modes done");
	endtask : t_modes
	initial begin
		rst_n = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		watchdog_hw_enable = 1'b0;
		brownout_hw_enable = 1'b0;
		brownout_hw_level = 2'h2;
		irq_pending = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(2);
		t_regs();
		t_lvd();
		t_resets();
		t_bor();
		t_modes();
		conclude();
	end
endmodule : tb
